// >>> rtl/wdt_cfg_pkg.sv
// Package with register map, field layout and decoded settings of the config word
`default_nettype none
package wdt_cfg_pkg;
   localparam logic [11:0] ADDR_CFG_WORD    = 12'h000;
   localparam logic [11:0] ADDR_WDT_CTRL    = 12'h004;
   localparam logic [11:0] ADDR_SETTINGS    = 12'h008;
   localparam int          POS_HARD_EN      = 23;
   localparam int          POS_PS_LO        = 16;
   localparam int          POS_CSM_LO       = 14;
   localparam int          POS_OSC_LO       = 8;
   localparam int          POS_SW_ON        = 0;
   localparam logic [4:0]  PS_MAX           = 5'h14;
   localparam logic [1:0]  OSC_MODE_OFF     = 2'h3;
   localparam logic [31:0] CFG_WORD_RESET   = 32'hffffffff;
   localparam logic [31:0] SLVERR_READ      = 32'h00000000;

   typedef struct packed {
      logic       wdtRun;
      logic       wdtLocked;
      logic [4:0] postscale;
      logic       clkSwitchEn;
      logic       failSafeEn;
      logic [1:0] primaryOscMode;
   } settings_s;
endpackage
`default_nettype wire

// >>> rtl/cfg_field_decode.sv
// Combinational decoder from captured config word to settings
`default_nettype none
module cfg_field_decode (
   input  wire logic [31:0]            cfgWord,
   input  wire logic                   swRunReq,
   output wdt_cfg_pkg::settings_s      settings
);
   logic [4:0] rawPs;
   logic [1:0] csm;
   always_comb begin
      rawPs = cfgWord[wdt_cfg_pkg::POS_PS_LO +: 5];
      csm   = cfgWord[wdt_cfg_pkg::POS_CSM_LO +: 2];
      settings.wdtLocked      = cfgWord[wdt_cfg_pkg::POS_HARD_EN];
      settings.wdtRun         = cfgWord[wdt_cfg_pkg::POS_HARD_EN] | swRunReq; // [RQ1] [RQ2]
      // Undefined codes fold onto the largest ratio
      settings.postscale      = (rawPs > wdt_cfg_pkg::PS_MAX) ? wdt_cfg_pkg::PS_MAX : rawPs; // [RQ3] [RQ4]
      settings.clkSwitchEn    = ~csm[1];                 // [RQ5] [RQ6] [RQ7]
      settings.failSafeEn     = (csm == 2'h0);           // [RQ5] [RQ6] [RQ7]
      settings.primaryOscMode = cfgWord[wdt_cfg_pkg::POS_OSC_LO +: 2];
   end
endmodule
`default_nettype wire

// >>> rtl/watchdog_clock_config_decode.sv
// Config word capture, decode and APB register access
//
// Notes on behaviour
// [RQ1] Hard-enable bit set: watchdog runs from reset, software cannot stop it.
// [RQ2] Hard-enable bit clear: watchdog starts off, software may switch it on.
// [RQ3] Postscale field selects divide ratio two to the field value, 1:1 to 1:1048576.
// [RQ4] Postscale codes above the highest defined value act as the largest ratio.
// [RQ5] Switch/monitor field upper bit set disables switching and fail-safe monitor.
// [RQ6] Switch/monitor field 01 enables switching, fail-safe monitor stays off.
// [RQ7] Switch/monitor field 00 enables switching and the fail-safe monitor.
// [RQ8] Programmer must not disable primary oscillator while it is the clock source.
// [RQ9] Config word captured after reset release, held until next reset, ignores writes.
`default_nettype none
module watchdog_clock_config_decode (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        clkEn,
   input  wire logic [31:0] nvmWord,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             wdtRun,
   output logic [4:0]       wdtPostscale,
   output logic             clkSwitchEn,
   output logic             failSafeEn,
   output logic             oscModeFault
);
   logic [31:0] nvmMeta_r, nvmSync_r, cfg_r, cfg_nxt;
   logic        loaded_r, loaded_nxt;
   logic [1:0]  fill_r, fill_nxt;
   logic        swOn_r, swOn_nxt;
   logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        run_r, csw_r, fsm_r, fault_r;
   logic [4:0]  ps_r;
   wdt_cfg_pkg::settings_s dec;

   cfg_field_decode u_dec (
      .cfgWord  (cfg_r),
      .swRunReq (swOn_r),
      .settings (dec)
   );

   // Capture only once both sync stages hold post-reset samples,
   // else the synchroniser's reset fill would be frozen instead
   always_comb begin
      fill_nxt   = {fill_r[0], 1'b1};
      cfg_nxt    = cfg_r;
      loaded_nxt = loaded_r;
      if (fill_r[1] && !loaded_r) begin
         cfg_nxt    = nvmSync_r;                         // [RQ9]
         loaded_nxt = 1'b1;
      end
   end

   // APB slave: zero wait states, unmapped address answers pslverr
   always_comb begin
      swOn_nxt    = swOn_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt  = prdata_r;
      if (psel && !penable) begin
         pready_nxt = 1'b1;
         prdata_nxt = wdt_cfg_pkg::SLVERR_READ;
         case (paddr)
            wdt_cfg_pkg::ADDR_CFG_WORD: begin
               if (!pwrite) prdata_nxt = cfg_r;          // Read only [RQ9]
            end
            wdt_cfg_pkg::ADDR_WDT_CTRL: begin
               if (pwrite) swOn_nxt = pwdata[wdt_cfg_pkg::POS_SW_ON]; // [RQ2]
               else prdata_nxt = {30'h0, dec.wdtLocked, dec.wdtRun};
            end
            wdt_cfg_pkg::ADDR_SETTINGS: begin
               if (!pwrite) prdata_nxt = {22'h0, dec.primaryOscMode, dec.postscale,
                                          dec.clkSwitchEn, dec.failSafeEn, dec.wdtRun};
            end
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         nvmMeta_r <= wdt_cfg_pkg::CFG_WORD_RESET;
         nvmSync_r <= wdt_cfg_pkg::CFG_WORD_RESET;
         cfg_r     <= wdt_cfg_pkg::CFG_WORD_RESET;
         loaded_r  <= 1'b0;
         fill_r    <= 2'h0;
         swOn_r    <= 1'b0;                              // [RQ2]
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
         run_r     <= 1'b0;
         ps_r      <= 5'h0;
         csw_r     <= 1'b0;
         fsm_r     <= 1'b0;
         fault_r   <= 1'b0;
      end else if (clkEn) begin
         nvmMeta_r <= nvmWord;
         nvmSync_r <= nvmMeta_r;
         cfg_r     <= cfg_nxt;
         loaded_r  <= loaded_nxt;
         fill_r    <= fill_nxt;
         swOn_r    <= swOn_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
         // All setting outputs but ps_r valid only once the word is held
         run_r     <= loaded_r & dec.wdtRun;             // [RQ1]
         ps_r      <= dec.postscale;                     // [RQ3]
         csw_r     <= loaded_r & dec.clkSwitchEn;        // [RQ5]
         fsm_r     <= loaded_r & dec.failSafeEn;         // [RQ7]
         fault_r   <= loaded_r & (dec.primaryOscMode == wdt_cfg_pkg::OSC_MODE_OFF); // [RQ8]
      end
   end

   assign pready       = pready_r;
   assign prdata       = prdata_r;
   assign pslverr      = pslverr_r;
   assign wdtRun       = run_r;
   assign wdtPostscale = ps_r;
   assign clkSwitchEn  = csw_r;
   assign failSafeEn   = fsm_r;
   assign oscModeFault = fault_r;
endmodule
`default_nettype wire

// >>> testbench/cfg_decode_asserts.sv
// Checker of decoded settings and APB answers
`default_nettype none
module cfg_decode_asserts (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        clkEn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [4:0]  wdtPostscale,
   input wire logic        clkSwitchEn,
   input wire logic        failSafeEn
);
   logic [2:0] upCnt_r, upCnt_nxt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   always_comb upCnt_nxt = (upCnt_r == 3'h7) ? upCnt_r : upCnt_r + 3'h1;
   // Only enabled edges move the capture pipeline
   always_ff @(posedge sys_clk) upCnt_r <= !resetn ? 3'h0 : clkEn ? upCnt_nxt : upCnt_r;
   property p_clamp; wdtPostscale <= 5'h14; endproperty
   a_clamp: assert property (p_clamp) else $error("postscale too big");
   property p_monitor; failSafeEn |-> clkSwitchEn; endproperty
   a_monitor: assert property (p_monitor) else $error("monitor without switch");
   // Settings must never move once capture has settled
   property p_hold; upCnt_r >= 3'h5 |-> $stable({wdtPostscale, clkSwitchEn, failSafeEn}); endproperty
   a_hold: assert property (p_hold) else $error("settings moved");
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_errpair; pslverr |-> pready && prdata == 32'h0; endproperty
   a_errpair: assert property (p_errpair) else $error("bad error answer");
   property p_unmapped; psel && !penable && paddr > 12'h008 |=> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
   property p_mapped; psel && !penable && paddr == 12'h004 |=> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped refused");
endmodule
bind watchdog_clock_config_decode cfg_decode_asserts u_chk (.sys_clk, .resetn, .clkEn, .psel, .penable, .paddr,
   .pready, .prdata, .pslverr, .wdtPostscale, .clkSwitchEn, .failSafeEn);
`default_nettype wire

// >>> testbench/watchdog_clock_config_decode_test.sv
// Self-checking bench for config decode
`default_nettype none
module watchdog_clock_config_decode_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic        clkEn = 1, wdtRun, clkSwitchEn, failSafeEn, oscModeFault;
   logic [4:0]  wdtPostscale;
   logic [11:0] paddr = 12'h000;
   logic [31:0] nvmWord = 32'hffffffff, pwdata = 32'h0, prdata, rd;
   int          fail_count = 0, comparisons = 0, ticks = 0;
   logic [31:0] rows [5] = '{32'hffe00b00, 32'hff744800, 32'hff7f8800, 32'hfff5c800, 32'hff6a0900};
   logic [8:0]  want [5] = '{9'h183, 9'h052, 9'h050, 9'h0d0, 9'h02b};
   watchdog_clock_config_decode DUT (.sys_clk, .resetn, .clkEn, .nvmWord, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .wdtRun, .wdtPostscale, .clkSwitchEn, .failSafeEn,
      .oscModeFault);
   always #2.5 sys_clk = ~sys_clk;
   task test_done;
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      ticks++;
      if (ticks == 2000) begin
         fail_count++;
         test_done;
      end
   end
   task chk(logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task boot(logic [31:0] w);
      @(posedge sys_clk) nvmWord <= w;
      resetn <= 0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1;
      // Two sync stages, capture, then the output registers
      repeat (6) @(posedge sys_clk);
   endtask
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge sys_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge sys_clk) penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   function automatic logic [31:0] st();
      return 32'({oscModeFault, wdtRun, wdtPostscale, clkSwitchEn, failSafeEn});
   endfunction
   initial begin
      for (int i = 0; i < 5; i++) begin
         boot(rows[i]);
         chk(st(), 32'(want[i]));
      end
      apb(1, 12'h004, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(32'(wdtRun), 32'h1);
      apb(1, 12'h000, 32'h0);
      apb(0, 12'h000, 32'h0);
      chk(rd, 32'hff6a0900);
      nvmWord <= 32'h0;
      repeat (4) @(posedge sys_clk);
      chk(st(), 32'h0ab);
      apb(0, 12'hffc, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      // Frozen clock: reset still clears, but nothing loads
      clkEn <= 0;
      boot(rows[1]);
      chk(st(), 32'h0);
      clkEn <= 1;
      repeat (6) @(posedge sys_clk);
      chk(st(), 32'(want[1]));
      boot(rows[0]);
      apb(1, 12'h004, 32'h0);
      apb(0, 12'h004, 32'h0);
      chk(rd, 32'h3);
      chk(32'(wdtRun), 32'h1);
      test_done;
   end
endmodule
`default_nettype wire
